// file: logic/iva_arbiter.sv
// interrupt vector arbiter with trap flag and port l edge interrupts
// What this block does
// - dispatch samples highest active source, even code
// - active trap always yields code FE
// - external pin gives FA, lower ranks smaller
// - nothing active selects lowest default slot
// - only enabled and pending sources compete
// - code replaces pc low byte, high kept
// - fetched vector loads pc, service starts
// - vector high byte at lower address
// - trap flag set on trap, reset clears
// - clear instruction clears trap flag unless a trap fetch comes in the same cycle
// - trap flag has no register address
// - fetching trap opcode into ir raises trap
// - trap opcode is all zeros
// - missing program memory reads as zero
// - stack underflow pop loads 7FFF
// - trap leaves global enable, flag blocks others
// - only another trap interrupts trap routine
// - trap return address is trap instruction
// - single trap flag, clear reenables maskables
// - eight port l edge inputs, one slot
// - per pin port l interrupt enable
// - per pin rising or falling edge select
// - per pin pending latch, no group flag
// - port l group enable plus global enable
// - disabled wake resumes after low power instr
// - enabled wake runs port l service first
//
// Register access over Avalon-MM and the register offsets were left to the implementer.
`timescale 1ns/1ps
`include "iva_consts.svh"

module iva_arbiter #(
    parameter int NSRC = 12                  // maskable sources, slots 2 to 13
) (
    input  wire logic               clk,
    input  wire logic               nrst,
    input  wire logic [2:0]         avs_address,      // word index
    input  wire logic               avs_read,
    input  wire logic               avs_write,
    input  wire logic [31:0]        avs_writedata,
    input  wire logic [3:0]         avs_byteenable,
    output logic      [31:0]        avs_readdata,
    output logic                    avs_waitrequest,
    input  wire iva_pkg::iva_fetch_s fetch,           // ir load from sequencer
    input  wire logic               dispatch_instr,   // vector dispatch starts
    input  wire logic               pending_clear_instr,
    input  wire logic               stack_pop,        // pop happened this cycle
    input  wire logic [8:0]         stack_ptr,        // pointer after the pop
    input  wire logic [6:0]         pc_hi,            // current pc high part
    input  wire logic [NSRC-1:0]    src_pend,         // index 0 lowest rank
    input  wire logic [NSRC-1:0]    src_en,
    input  wire logic [7:0]         portl_pin,
    input  wire logic               low_power,        // halt or idle
    input  wire logic [7:0]         pm_data,
    input  wire logic               pm_present,
    input  wire logic               pm_valid,
    output logic                    pm_rd,
    output logic      [14:0]        pm_addr,
    output logic                    pc_load,
    output logic      [14:0]        pc_value,
    output logic                    ir_load,
    output logic      [7:0]         ir_byte,
    output logic                    trap_pending_flag,
    output logic      [14:0]        trap_ret_pc,
    output logic                    irq_req,
    output logic                    wake,
    output logic                    wake_to_isr
);
    // ------------------------------------------------------------
    // state and combinational terms
    // ------------------------------------------------------------
    iva_pkg::iva_st_s st;                    // registered state
    iva_pkg::iva_st_s next_st;               // next state
    logic [7:0]       edge_evt;              // per pin trigger this cycle
    logic [15:0]      act;                   // active slot vector
    logic [3:0]       win;                   // winning slot
    logic [7:0]       fbyte;                 // fetched byte after zero fill
    logic [7:0]       pbyte;                 // vector byte after zero fill
    logic             portl_act;             // port l takes part
    logic             mask_any;              // any maskable active
    logic             req_rd;                // bus read request
    logic             req_wr;                // bus write request
    logic [31:0]      rd_mux;                // register read value

    // ------------------------------------------------------------
    // per pin edge detection
    // ------------------------------------------------------------
    genvar gi;
    generate
        for (gi = 0; gi < 8; gi++) begin : g_edge
            // polarity 1 selects falling edge, 0 rising edge
            assign edge_evt[gi] = st.edge_polarity_select[gi] ? (st.pins_q[gi] & ~portl_pin[gi])
                                               : (~st.pins_q[gi] & portl_pin[gi]);
        end
    endgenerate

    // ------------------------------------------------------------
    // arbitration inputs
    // ------------------------------------------------------------
    // port l counts only with group enable and a pin both enabled and pending
    assign portl_act = st.portl_group_irq_enable & (|(st.edge_wake_enable & st.edge_event_pending));
    // slot 15 trap, 14 reserved, 2..13 sources, 1 port l, 0 default
    assign act = {st.trap, 1'b0, src_pend & src_en, portl_act, 1'b1};
    assign mask_any = |act[14:1];

    // highest set slot wins, slot 0 always set as default
    always_comb begin
        win = `IVA_SLOT_DEFAULT;
        for (int i = 1; i < 16; i++) begin
            if (act[i]) begin
                win = 4'(i);
            end
        end
    end

    // nonexistent memory returns zero bytes
    assign fbyte = fetch.present ? fetch.data : `IVA_TRAP_OP;
    assign pbyte = pm_present ? pm_data : `IVA_TRAP_OP;

    // ------------------------------------------------------------
    // bus decode
    // ------------------------------------------------------------
    assign req_rd = avs_read & ~avs_write;
    assign req_wr = avs_write & ~avs_read;

    // register read mux, unmapped reads zero; trap flag never appears
    always_comb begin
        rd_mux = 32'h0000_0000;
        unique case (avs_address)
            `IVA_IDX_EDGE_WAKE_ENABLE:  rd_mux[7:0] = st.edge_wake_enable;
            `IVA_IDX_EDGE_POLARITY_SELECT: rd_mux[7:0] = st.edge_polarity_select;
            `IVA_IDX_EDGE_EVENT_PENDING: rd_mux[7:0] = st.edge_event_pending;
            `IVA_IDX_CTRL: begin
                rd_mux[`IVA_CTRL_GIE]  = st.global_irq_enable;
                rd_mux[`IVA_CTRL_PORTL_GROUP_IRQ_ENABLE] = st.portl_group_irq_enable;
            end
            `IVA_IDX_STAT: begin
                rd_mux[0]    = (st.state != iva_pkg::ST_IDLE);
                rd_mux[15:8] = st.code;
            end
            default: rd_mux = 32'h0000_0000;
        endcase
    end

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        next_st         = st;
        next_st.pins_q  = portl_pin;
        next_st.pc_load = 1'b0;
        next_st.ir_load = 1'b0;
        next_st.pm_rd   = 1'b0;
        next_st.wake    = 1'b0;

        // bus slave: waitrequest drops one cycle, write lands at that edge
        next_st.waitreq = 1'b1;
        if ((req_rd | req_wr) & st.waitreq) begin
            next_st.waitreq = 1'b0;
            next_st.rdata   = rd_mux;
        end
        if (req_wr & ~st.waitreq & avs_byteenable[0]) begin
            unique case (avs_address)
                `IVA_IDX_EDGE_WAKE_ENABLE:  next_st.edge_wake_enable  = avs_writedata[7:0];
                `IVA_IDX_EDGE_POLARITY_SELECT: next_st.edge_polarity_select = avs_writedata[7:0];
                `IVA_IDX_EDGE_EVENT_PENDING: next_st.edge_event_pending = avs_writedata[7:0];
                `IVA_IDX_CTRL: begin
                    next_st.global_irq_enable  = avs_writedata[`IVA_CTRL_GIE];
                    next_st.portl_group_irq_enable = avs_writedata[`IVA_CTRL_PORTL_GROUP_IRQ_ENABLE];
                end
                default: ;
            endcase
        end
        // edge events latch, a set beats a software write
        next_st.edge_event_pending = next_st.edge_event_pending | edge_evt;

        // ir load with trap detection; gie is left alone
        if (fetch.valid) begin
            next_st.ir_load = 1'b1;
            next_st.ir_byte = fbyte;
            if (fbyte == `IVA_TRAP_OP) begin
                next_st.trap        = 1'b1;
                next_st.trap_ret_pc = fetch.pc;
            end
        end
        // clear instruction drops the single flag unless a trap arrives now
        if (pending_clear_instr & ~(fetch.valid & (fbyte == `IVA_TRAP_OP))) begin
            next_st.trap = 1'b0;
        end

        // trap request is non-maskable; flag blocks maskable requests
        next_st.irq_req = next_st.trap | (st.global_irq_enable & ~st.trap & mask_any);

        // port l wake out of halt or idle
        if (low_power & (|(st.edge_wake_enable & st.edge_event_pending))) begin
            next_st.wake        = 1'b1;
            next_st.wake_to_isr = st.global_irq_enable & portl_act;
        end

        // vector dispatch sequencer
        unique case (st.state)
            iva_pkg::ST_IDLE: begin
                if (dispatch_instr) begin
                    next_st.code    = `IVA_CODE_BASE | {3'b000, win, 1'b0};
                    next_st.pm_addr = {pc_hi, `IVA_CODE_BASE | {3'b000, win, 1'b0}};
                    next_st.pm_rd   = 1'b1;
                    next_st.state   = iva_pkg::ST_HI;
                end
            end
            iva_pkg::ST_HI: begin
                next_st.pm_rd = ~pm_valid;
                if (pm_valid) begin
                    next_st.vec_hi  = pbyte[6:0];
                    next_st.pm_addr = {st.pm_addr[14:1], 1'b1};
                    next_st.pm_rd   = 1'b1;
                    next_st.state   = iva_pkg::ST_LO;
                end
            end
            iva_pkg::ST_LO: begin
                next_st.pm_rd = ~pm_valid;
                if (pm_valid) begin
                    next_st.pc_value = {st.vec_hi, pbyte};
                    next_st.state    = iva_pkg::ST_LOAD;
                end
            end
            iva_pkg::ST_LOAD: begin
                next_st.pc_load = 1'b1;
                next_st.state   = iva_pkg::ST_IDLE;
            end
        endcase

        // popping past the stack limit forces the top address
        if (stack_pop & (stack_ptr > `IVA_STACK_LIMIT)) begin
            next_st.pc_load  = 1'b1;
            next_st.pc_value = `IVA_UNDERFLOW_PC;
        end
    end

    // ------------------------------------------------------------
    // state register
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!nrst) begin
            st         <= '0;
            st.state   <= iva_pkg::ST_IDLE;
            st.edge_wake_enable    <= `IVA_RST_BYTE;
            st.edge_polarity_select   <= `IVA_RST_BYTE;
            st.edge_event_pending   <= `IVA_RST_BYTE;
            st.pins_q  <= `IVA_RST_PINS;
            st.trap    <= 1'b0;
            st.waitreq <= 1'b1;
        end else begin
            st <= next_st;
        end
    end

    // outputs straight from flops
    assign avs_readdata      = st.rdata;
    assign avs_waitrequest   = st.waitreq;
    assign pm_rd             = st.pm_rd;
    assign pm_addr           = st.pm_addr;
    assign pc_load           = st.pc_load;
    assign pc_value          = st.pc_value;
    assign ir_load           = st.ir_load;
    assign ir_byte           = st.ir_byte;
    assign trap_pending_flag = st.trap;
    assign trap_ret_pc       = st.trap_ret_pc;
    assign irq_req           = st.irq_req;
    assign wake              = st.wake;
    assign wake_to_isr       = st.wake_to_isr;

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    sequence s_trap_fetch;
        fetch.valid && (fbyte == `IVA_TRAP_OP);
    endsequence
    sequence s_dispatch;
        (st.state == iva_pkg::ST_IDLE) && dispatch_instr;
    endsequence
    // clear instruction with no trap fetch beside it
    sequence s_trap_clear;
        pending_clear_instr && !fetch.valid;
    endsequence

    a_trap_code_ff: assert property (s_dispatch and st.trap |=> st.code == `IVA_CODE_TRAP)
        else $error("trap did not give code FE");
    a_ext_code_fa: assert property (s_dispatch and (!st.trap && src_pend[NSRC-1]
        && src_en[NSRC-1]) |=> st.code == 8'hFA)
        else $error("external source did not give FA");
    a_default_code: assert property (s_dispatch and (act[15:1] == 15'h0000)
        |=> st.code == `IVA_CODE_BASE)
        else $error("idle dispatch did not give default code");
    a_pc_low_swap: assert property (s_dispatch |=> pm_rd && pm_addr[14:8] == $past(pc_hi)
        && pm_addr[7:0] == st.code && !pm_addr[0])
        else $error("vector address not formed from pc high and code");
    a_trap_set_flag: assert property (s_trap_fetch |=> trap_pending_flag
        && trap_ret_pc == $past(fetch.pc))
        else $error("trap fetch did not set flag");
    a_clear_flag: assert property (pending_clear_instr && !fetch.valid |=> !trap_pending_flag)
        else $error("clear instruction left trap flag set");
    // a clear in the same cycle legally drops the request
    a_trap_blocks: assert property (st.trap && !pending_clear_instr |=> irq_req)
        else $error("trap flag without request");
    a_mask_blocked: assert property (st.trap && !$past(st.trap) && mask_any
        |-> ##1 irq_req)
        else $error("request dropped under trap");
    a_underflow_pc: assert property (stack_pop && stack_ptr > `IVA_STACK_LIMIT
        |=> pc_load && pc_value == `IVA_UNDERFLOW_PC)
        else $error("underflow did not load top address");
    a_vector_load: assert property (s_dispatch |-> ##[3:40] pc_load)
        else $error("vector never loaded");
    a_edge_latch: assert property (|edge_evt |=> (st.edge_event_pending & $past(edge_evt)) == $past(edge_evt))
        else $error("edge event not latched");
    a_bus_answer: assert property ((req_rd || req_wr) && st.waitreq |=> !avs_waitrequest)
        else $error("bus not answered in one cycle");
    // blank program memory decodes as the trap opcode
    a_blank_fetch: assert property (fetch.valid && !fetch.present
        |=> ir_load && ir_byte == `IVA_TRAP_OP && trap_pending_flag)
        else $error("blank fetch did not load trap opcode");
    // port l alone active takes its shared slot
    a_portl_slot: assert property (s_dispatch and (act[15:2] == 14'h0000) and portl_act
        |=> st.code == (`IVA_CODE_BASE | {3'b000, `IVA_SLOT_PORTL, 1'b0}))
        else $error("port l dispatch did not give its slot");
    // wake with group and global enable runs the service routine
    a_wake_isr: assert property (low_power && st.global_irq_enable && portl_act
        |=> wake && wake_to_isr)
        else $error("enabled wake not sent to service");
    // wake with group enable off resumes in line
    a_wake_plain: assert property (low_power && |(st.edge_wake_enable & st.edge_event_pending) && !st.portl_group_irq_enable
        |=> wake && !wake_to_isr)
        else $error("disabled wake sent to service");
    // once the single flag is cleared, maskables request again
    a_clear_reopen: assert property (s_trap_clear ##1 (st.global_irq_enable && mask_any)
        |=> irq_req)
        else $error("maskable not accepted after clear");

endmodule // iva_arbiter

// file: logic/iva_consts.svh
// constants of the interrupt vector arbiter
`ifndef IVA_CONSTS_SVH
`define IVA_CONSTS_SVH
// vector codes and opcodes
`define IVA_CODE_BASE     8'hE0
`define IVA_CODE_TRAP     8'hFE
`define IVA_TRAP_OP       8'h00
`define IVA_SLOT_TRAP     4'hF
`define IVA_SLOT_PORTL    4'h1
`define IVA_SLOT_DEFAULT  4'h0
// stack underflow handling
`define IVA_STACK_LIMIT   9'h06F
`define IVA_UNDERFLOW_PC  15'h7FFF
// register word indices (byte address = 4 * index)
`define IVA_IDX_EDGE_WAKE_ENABLE      3'h0
`define IVA_IDX_EDGE_POLARITY_SELECT     3'h1
`define IVA_IDX_EDGE_EVENT_PENDING     3'h2
`define IVA_IDX_CTRL      3'h3
`define IVA_IDX_STAT      3'h4
// control bits and reset values
`define IVA_CTRL_GIE      0
`define IVA_CTRL_PORTL_GROUP_IRQ_ENABLE     1
`define IVA_RST_BYTE      8'h00
// pin history after reset: all high, so rising select sees no false edge
`define IVA_RST_PINS      8'hFF
`endif

// file: logic/iva_pkg.sv
// types of the interrupt vector arbiter
package iva_pkg;
    // vector dispatch sequencer states
    typedef enum logic [1:0] {ST_IDLE, ST_HI, ST_LO, ST_LOAD} iva_state_e;
    // one instruction register load from the sequencer
    typedef struct packed {
        logic        valid;   // byte is being loaded into the ir
        logic        present; // location exists and is programmed
        logic [7:0]  data;    // raw fetched byte
        logic [14:0] pc;      // address it was fetched from
    } iva_fetch_s;
    // whole module state
    typedef struct packed {
        iva_state_e  state;
        logic [7:0]  edge_wake_enable;
        logic [7:0]  edge_polarity_select;
        logic [7:0]  edge_event_pending;
        logic        global_irq_enable;
        logic        portl_group_irq_enable;
        logic [7:0]  pins_q;
        logic        trap;
        logic [14:0] trap_ret_pc;
        logic [7:0]  code;
        logic [6:0]  vec_hi;
        logic [14:0] pm_addr;
        logic        pm_rd;
        logic        pc_load;
        logic [14:0] pc_value;
        logic        ir_load;
        logic [7:0]  ir_byte;
        logic        irq_req;
        logic        wake;
        logic        wake_to_isr;
        logic        waitreq;
        logic [31:0] rdata;
    } iva_st_s;
endpackage

// file: tb/iva_pm_model.sv
// program memory model that answers the arbiter's vector reads
`timescale 1ns/1ps

module iva_pm_model (
    input  wire logic        clk,
    input  wire logic        pm_rd,
    input  wire logic [14:0] pm_addr,
    output logic      [7:0]  pm_data,
    output logic             pm_present,
    output logic             pm_valid
);
    logic slow;   // alternates prompt and late answers
    logic waited; // one stall cycle already spent

    // -------------------------------------------------------------
    // answer each read; scramble data between answers
    // -------------------------------------------------------------
    initial begin
        pm_data    = 8'h00;
        pm_present = 1'b0;
        pm_valid   = 1'b0;
        slow       = 1'b0;
        waited     = 1'b0;
    end

    always @(posedge clk) begin
        if (pm_valid) begin
            pm_valid   <= 1'b0;
            pm_present <= 1'b0;
            pm_data    <= ~pm_data; // released bus shows no stale byte
        end else if (pm_rd && slow && !waited) begin
            waited <= 1'b1;
        end else if (pm_rd) begin
            // even address holds high byte, odd the low byte
            pm_data    <= pm_addr[0] ? (pm_addr[7:0] ^ 8'hC3) : (pm_addr[7:0] ^ 8'h5A);
            pm_present <= 1'b1;
            pm_valid   <= 1'b1;
            waited     <= 1'b0;
            slow       <= ~slow;
        end
    end
endmodule // iva_pm_model

// file: tb/iva_arbiter_tb.sv
// self-checking testbench of the interrupt vector arbiter
`timescale 1ns/1ps

module iva_arbiter_tb;
    logic                clk, nrst, avs_read, avs_write, avs_waitrequest;
    logic [2:0]          avs_address;
    logic [31:0]         avs_writedata, avs_readdata, rd;
    logic [3:0]          avs_byteenable;
    iva_pkg::iva_fetch_s fetch;
    logic                dispatch_instr, pending_clear_instr, stack_pop, low_power;
    logic [8:0]          stack_ptr;
    logic [6:0]          pc_hi;
    logic [11:0]         src_pend, src_en;
    logic [7:0]          portl_pin, pm_data, ir_byte;
    logic                pm_present, pm_valid, pm_rd, pc_load, ir_load;
    logic [14:0]         pm_addr, pc_value, trap_ret_pc;
    logic                trap_pending_flag, irq_req, wake, wake_to_isr;
    int                  err_total, total_checks, cycles;

    iva_arbiter #(.NSRC(12)) DUT (.clk(clk), .nrst(nrst), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .fetch(fetch), .dispatch_instr(dispatch_instr),
        .pending_clear_instr(pending_clear_instr), .stack_pop(stack_pop),
        .stack_ptr(stack_ptr), .pc_hi(pc_hi), .src_pend(src_pend), .src_en(src_en),
        .portl_pin(portl_pin), .low_power(low_power), .pm_data(pm_data),
        .pm_present(pm_present), .pm_valid(pm_valid), .pm_rd(pm_rd), .pm_addr(pm_addr),
        .pc_load(pc_load), .pc_value(pc_value), .ir_load(ir_load), .ir_byte(ir_byte),
        .trap_pending_flag(trap_pending_flag), .trap_ret_pc(trap_ret_pc),
        .irq_req(irq_req), .wake(wake), .wake_to_isr(wake_to_isr));

    iva_pm_model pm (.clk(clk), .pm_rd(pm_rd), .pm_addr(pm_addr), .pm_data(pm_data),
        .pm_present(pm_present), .pm_valid(pm_valid));

    // -------------------------------------------------------------
    // clock, timeout, verdict, check and bus tasks
    // -------------------------------------------------------------
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            err_total++;
            print_verdict();
        end
    end

    task automatic print_verdict();
        $display("checks %0d errors %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask

    task automatic check(string name, logic [31:0] seen, logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // one avalon transfer, held until waitrequest is sampled low
    task automatic bus(logic wr, logic [2:0] a, logic [31:0] d);
        @(posedge clk);
        avs_address   <= a;
        avs_writedata <= d;
        avs_write     <= wr;
        avs_read      <= ~wr;
        do begin
            @(posedge clk);
        end while (avs_waitrequest !== 1'b0);
        rd = avs_readdata;
        avs_read  <= 1'b0;
        avs_write <= 1'b0;
    endtask

    // dispatch; vector address and loaded pc from the model's contents
    task automatic dispatch_chk(logic [7:0] code);
        logic [7:0] hi;
        logic [7:0] lo;
        hi = code ^ 8'h5A;
        lo = (code | 8'h01) ^ 8'hC3;
        @(posedge clk);
        dispatch_instr <= 1'b1;
        @(posedge clk);
        dispatch_instr <= 1'b0;
        for (int i = 0; i < 50 && pm_rd !== 1'b1; i++) @(posedge clk);
        check("vector addr", pm_addr, {pc_hi, code});
        for (int i = 0; i < 50 && pc_load !== 1'b1; i++) @(posedge clk);
        check("pc load", pc_load, 1'b1);
        check("pc value", pc_value, {hi[6:0], lo});
    endtask

    task automatic do_fetch(logic present, logic [7:0] d, logic [14:0] a);
        @(posedge clk);
        fetch <= '{valid: 1'b1, present: present, data: d, pc: a};
        @(posedge clk);
        fetch.valid <= 1'b0;
        @(posedge clk);
    endtask

    // -------------------------------------------------------------
    // scenarios
    // -------------------------------------------------------------
    task automatic t_regs();
        for (int i = 0; i < 5; i++) begin
            bus(1'b0, i[2:0], 32'h0000_0000);
            check("reset reg", rd, 32'h0000_0000);
        end
        check("trap reset", trap_pending_flag, 1'b0);
        bus(1'b1, 3'h0, 32'h0000_00A5);
        bus(1'b0, 3'h0, 32'h0000_0000);
        check("enable reg", rd, 32'h0000_00A5);
        avs_byteenable <= 4'h0;
        bus(1'b1, 3'h0, 32'h0000_005A);
        avs_byteenable <= 4'h1;
        bus(1'b0, 3'h0, 32'h0000_0000);
        check("no byte lane", rd, 32'h0000_00A5);
        bus(1'b1, 3'h7, 32'h0000_00FF);
        bus(1'b0, 3'h7, 32'h0000_0000);
        check("unmapped", rd, 32'h0000_0000);
    endtask

    task automatic t_arbitrate();
        src_en   <= 12'h7FF;
        src_pend <= 12'h000;
        dispatch_chk(8'hE0);
        src_pend <= 12'h801;
        dispatch_chk(8'hE4);
        src_en <= 12'hFFF;
        dispatch_chk(8'hFA);
        bus(1'b0, 3'h4, 32'h0000_0000);
        check("last code", rd, 32'h0000_FA00);
    endtask

    task automatic t_trap();
        bus(1'b1, 3'h3, 32'h0000_0001);
        do_fetch(1'b1, 8'h00, 15'h1234);
        check("trap set", trap_pending_flag, 1'b1);
        check("ir load", ir_load, 1'b1);
        check("trap pc", trap_ret_pc, 15'h1234);
        bus(1'b0, 3'h3, 32'h0000_0000);
        check("gie kept", rd[0], 1'b1);
        dispatch_chk(8'hFE);
        @(posedge clk);
        pending_clear_instr <= 1'b1;
        @(posedge clk);
        pending_clear_instr <= 1'b0;
        @(posedge clk);
        check("trap clear", trap_pending_flag, 1'b0);
        @(posedge clk);
        check("maskable back", irq_req, 1'b1);
        dispatch_chk(8'hFA);
        do_fetch(1'b0, 8'h55, 15'h7FFE);
        check("blank byte", ir_byte, 8'h00);
        check("blank trap", trap_pending_flag, 1'b1);
        @(posedge clk);
        pending_clear_instr <= 1'b1;
        @(posedge clk);
        pending_clear_instr <= 1'b0;
        src_pend <= 12'h000;
    endtask

    task automatic t_stack();
        @(posedge clk);
        stack_pop <= 1'b1;
        stack_ptr <= 9'h070;
        @(posedge clk);
        stack_pop <= 1'b0;
        for (int i = 0; i < 20 && pc_load !== 1'b1; i++) @(posedge clk);
        check("underflow pc", pc_value, 15'h7FFF);
    endtask

    task automatic t_portl();
        bus(1'b1, 3'h0, 32'h0000_0003);
        bus(1'b1, 3'h1, 32'h0000_0002);
        bus(1'b1, 3'h3, 32'h0000_0003);
        bus(1'b1, 3'h2, 32'h0000_0000);
        portl_pin <= 8'h01;
        bus(1'b0, 3'h2, 32'h0000_0000);
        check("pending", rd, 32'h0000_0003);
        dispatch_chk(8'hE2);
        low_power <= 1'b1;
        for (int i = 0; i < 20 && wake !== 1'b1; i++) @(posedge clk);
        check("wake isr", wake_to_isr, 1'b1);
        low_power <= 1'b0;
        bus(1'b1, 3'h3, 32'h0000_0001);
        low_power <= 1'b1;
        repeat (2) @(posedge clk);
        for (int i = 0; i < 20 && wake !== 1'b1; i++) @(posedge clk);
        check("wake plain", {wake, wake_to_isr}, 2'b10);
    endtask

    // -------------------------------------------------------------
    // main sequence
    // -------------------------------------------------------------
    initial begin
        {err_total, total_checks, cycles} = '0;
        nrst = 1'b0;
        {avs_read, avs_write, avs_address, avs_writedata} = '0;
        avs_byteenable = 4'h1;
        fetch = '0;
        {dispatch_instr, pending_clear_instr, stack_pop, low_power} = '0;
        stack_ptr = 9'h080;
        pc_hi = 7'h21;
        {src_pend, src_en} = '0;
        portl_pin = 8'h02;
        repeat (3) @(posedge clk);
        nrst <= 1'b1;
        t_regs();
        t_arbitrate();
        t_trap();
        t_stack();
        t_portl();
        print_verdict();
    end
endmodule // iva_arbiter_tb
